// ===== design/dcdt_pkg.sv
`default_nettype none
package dcdt_pkg;
  // chain clock divider
  localparam logic [7:0]  DIV_RESET      = 8'h0f;
  localparam logic [7:0]  DIV_MIN        = 8'h07;
  localparam logic [7:0]  DIV_LOW_SUM    = 8'h0e;   // low+high terminal counts at minimum
  // register byte offsets
  localparam logic [11:0] ADDR_CFG       = 12'h000;
  localparam logic [11:0] ADDR_DATA0     = 12'h004;
  localparam logic [11:0] ADDR_DATA1     = 12'h008;
  localparam logic [11:0] ADDR_DATA2     = 12'h00c;
  localparam logic [11:0] ADDR_RAMP      = 12'h010;
  localparam logic [11:0] ADDR_STAT      = 12'h014;
  // config fields
  localparam int          CFG_DIV_LSB    = 0;
  localparam int          CFG_CNT_LSB    = 8;
  localparam int          CFG_PERIODIC   = 10;
  localparam int          CFG_REFMUX     = 11;
  localparam logic [1:0]  CNT_RESET      = 2'h0;
  localparam logic [1:0]  CNT_FORBIDDEN  = 2'h3;
  // datagram shape
  localparam int          DGRAM_BITS     = 12;
  localparam logic [3:0]  BIT_TOP        = 4'hb;
  localparam logic [1:0]  LEAD_LAST      = 2'h1;
  localparam logic [1:0]  TRAIL_LAST     = 2'h1;
  localparam logic [1:0]  NXM_FAST_LAST  = 2'h1;
  localparam logic [1:0]  NXM_SLOW_LAST  = 2'h2;
  // periodic rate: one datagram per 2^15 units of sum(2^-prescaler)
  localparam int          RAMP_W         = 4;
  localparam logic [16:0] PER_UNIT       = 17'h08000;
  localparam int          PER_ACC_W      = 30;
  typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_BITS, ST_NXM, ST_TRAIL} dcdt_state_t;
endpackage
`default_nettype wire

// ===== design/dcdt_div_if.sv
`default_nettype none
interface dcdt_div_if;
  logic [7:0] divider;
  logic       run;
  logic       half_tick;
  modport ctrl (output divider, output run, input half_tick);
  modport div  (input divider, input run, output half_tick);
endinterface
`default_nettype wire

// ===== design/dcdt_clkdiv.sv
`default_nettype none
module dcdt_clkdiv (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  // divider control
  dcdt_div_if.div   div_if
);
  logic [7:0] cnt;
  logic       high_ph;
  logic [7:0] half_last;
  logic [7:0] gap;
  logic [7:0] prev_gap;

  // short settings stretch the low half so the period stays at minimum
  always_comb begin
    if (div_if.divider >= dcdt_pkg::DIV_MIN || high_ph) begin
      half_last = div_if.divider;
    end else begin
      half_last = dcdt_pkg::DIV_LOW_SUM - div_if.divider;
    end
  end

  // each half lasts divider plus one cycles, except the low half when divider is below 7
  // restart count and flip phase when cnt reaches half_last
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt              <= 8'h00;
      high_ph          <= 1'b0;
      div_if.half_tick <= 1'b0;
    end else if (!div_if.run) begin
      cnt              <= 8'h00;
      high_ph          <= 1'b0;
      div_if.half_tick <= 1'b0;
    end else if (cnt == half_last) begin
      cnt              <= 8'h00;
      high_ph          <= ~high_ph;
      div_if.half_tick <= 1'b1;
    end else begin
      cnt              <= cnt + 8'h01;
      div_if.half_tick <= 1'b0;
    end
  end

  // helper: cycles between half ticks, for checking only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap      <= 8'h00;
      prev_gap <= 8'h00;
    end else if (!div_if.run) begin
      gap      <= 8'h00;
      prev_gap <= 8'h00;
    end else if (div_if.half_tick) begin
      gap      <= 8'h01;
      prev_gap <= gap;
    end else begin
      gap      <= gap + 8'h01;
    end
  end

  property p_half_len;
    @(posedge clk_i) disable iff (sys_rst_i)
    (div_if.run && div_if.half_tick && prev_gap != 8'h00 && $stable(div_if.divider)
      && div_if.divider >= dcdt_pkg::DIV_MIN) |-> (gap == div_if.divider + 8'h01);
  endproperty
  a_half_len: assert property (p_half_len) else $error("half period not divider plus one");

  property p_short_period;
    @(posedge clk_i) disable iff (sys_rst_i)
    (div_if.run && div_if.half_tick && prev_gap != 8'h00 && $stable(div_if.divider)
      && div_if.divider < dcdt_pkg::DIV_MIN) |-> (gap + prev_gap == 8'h10);
  endproperty
  a_short_period: assert property (p_short_period) else $error("short divider period wrong");
endmodule
`default_nettype wire

// ===== design/dcdt_top.sv
// Contract
// - eight-bit divider sets chain clock; legal range 7 to 255.
// - divider resets to 15.
// - below 7 the clock is no faster, only asymmetric.
// - chain clock equals system clock over two times divider plus one.
// - next-motor gap is one clock at 7, one and a half above.
// - frame is lead clock, bits plus gap per driver, trail clock.
// - two-bit driver count, codes 0..2 mean 1..3, code 3 forbidden.
// - by default datagrams go out only on demand.
// - on-demand mode sends nothing while all motors rest; a datagram register write still sends a frame.
// - on-demand mode samples multiplexed switches only during frames.
// - on-demand halt persists until the next datagram.
// - on-demand mode applies no current scaling at rest.
// - periodic mode keeps sending and sampling at rest.
// - periodic mode releases halt once the switch is inactive.
// - periodic mode scales current even at zero velocity.
// - periodic rate is clock times sum of 2^-prescaler over 32768.
// - chain select also steers the reference switch multiplexer.
//
// The APB register port and the register addresses were left to the implementer.
`default_nettype none
module dcdt_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // apb slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // motion core
  input  wire logic [2:0]  motor_active_i,
  output logic      [2:0]  motor_halt_o,
  output logic             current_scale_en_o,
  // reference switch pins
  input  wire logic [2:0]  ref_i,
  // driver chain
  output logic             chain_sck_o,
  output logic             chain_sel_n_o,
  output logic             chain_sdo_o
);
  dcdt_div_if div_if ();

  localparam int PER_ACC_W_L = dcdt_pkg::PER_ACC_W;
  logic [7:0]              chain_clock_divider;
  logic [1:0]              chain_driver_count;
  logic                    periodic;
  logic                    refmux;
  logic [11:0]             dgram [3];
  logic [3:0]              ramp_div [3];
  logic                    send_pend;
  logic                    per_pend;
  logic                    per_tick;
  logic [PER_ACC_W_L-1:0]  per_acc;
  logic [2:0]              ref_meta;
  logic [2:0]              ref_sync;
  logic [2:0]              left_sw;
  logic [2:0]              right_sw;
  dcdt_pkg::dcdt_state_t   state;
  logic [1:0]              half_cnt;
  logic [3:0]              bit_idx;
  logic [1:0]              drv_idx;
  logic                    start;
  logic                    frame_end;
  logic                    wr_acc;
  logic                    rd_acc;
  logic [1:0]              nxm_last;
  logic [16:0]             per_inc;
  logic [PER_ACC_W_L:0]    per_sum;
  logic [31:0]             next_rdata;
  logic                    next_err;
  logic [9:0]              halves_seen;
  logic [9:0]              halves_want;

  dcdt_clkdiv u_clkdiv (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .div_if    (div_if)
  );

  assign div_if.divider = chain_clock_divider;
  assign div_if.run     = (state != dcdt_pkg::ST_IDLE);

  // one wait state: answer on the edge after setup plus one access cycle
  assign wr_acc = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pready_o && !pwrite_i;

  // read mux, decoded while the access phase waits
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b0;
    if (paddr_i == dcdt_pkg::ADDR_CFG) begin
      next_rdata[dcdt_pkg::CFG_DIV_LSB +: 8] = chain_clock_divider;
      next_rdata[dcdt_pkg::CFG_CNT_LSB +: 2] = chain_driver_count;
      next_rdata[dcdt_pkg::CFG_PERIODIC]     = periodic;
      next_rdata[dcdt_pkg::CFG_REFMUX]       = refmux;
    end else if (paddr_i == dcdt_pkg::ADDR_DATA0) begin
      next_rdata[11:0] = dgram[0];
    end else if (paddr_i == dcdt_pkg::ADDR_DATA1) begin
      next_rdata[11:0] = dgram[1];
    end else if (paddr_i == dcdt_pkg::ADDR_DATA2) begin
      next_rdata[11:0] = dgram[2];
    end else if (paddr_i == dcdt_pkg::ADDR_RAMP) begin
      next_rdata[11:0] = {ramp_div[2], ramp_div[1], ramp_div[0]};
    end else if (paddr_i == dcdt_pkg::ADDR_STAT) begin
      next_rdata[10:0] = {current_scale_en_o, right_sw, left_sw, motor_halt_o,
                          (state != dcdt_pkg::ST_IDLE)};
    end else begin
      next_err = 1'b1;
    end
  end

  // apb handshake and read data
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && next_err;
      if (rd_acc) begin
        prdata_o <= next_rdata;
      end
    end
  end

  // configuration writes
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      chain_clock_divider <= dcdt_pkg::DIV_RESET;
      chain_driver_count  <= dcdt_pkg::CNT_RESET;
      periodic            <= 1'b0;
      refmux              <= 1'b0;
      ramp_div            <= '{default: 4'h0};
    end else if (wr_acc) begin
      if (paddr_i == dcdt_pkg::ADDR_CFG) begin
        // full eight-bit divider, any value kept
        chain_clock_divider <= pwdata_i[dcdt_pkg::CFG_DIV_LSB +: 8];
        // forbidden count code is dropped, old count stays
        if (pwdata_i[dcdt_pkg::CFG_CNT_LSB +: 2] != dcdt_pkg::CNT_FORBIDDEN) begin
          chain_driver_count <= pwdata_i[dcdt_pkg::CFG_CNT_LSB +: 2];
        end
        periodic <= pwdata_i[dcdt_pkg::CFG_PERIODIC];
        refmux   <= pwdata_i[dcdt_pkg::CFG_REFMUX];
      end else if (paddr_i == dcdt_pkg::ADDR_RAMP) begin
        ramp_div[0] <= pwdata_i[3:0];
        ramp_div[1] <= pwdata_i[7:4];
        ramp_div[2] <= pwdata_i[11:8];
      end
    end
  end

  // datagram words; a write asks for one transfer
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dgram     <= '{default: 12'h000};
      send_pend <= 1'b0;
    end else begin
      if (wr_acc && paddr_i == dcdt_pkg::ADDR_DATA0) begin
        dgram[0] <= pwdata_i[11:0];
      end else if (wr_acc && paddr_i == dcdt_pkg::ADDR_DATA1) begin
        dgram[1] <= pwdata_i[11:0];
      end else if (wr_acc && paddr_i == dcdt_pkg::ADDR_DATA2) begin
        dgram[2] <= pwdata_i[11:0];
      end
      // set wins over the clear taken by a frame start
      if (wr_acc && (paddr_i == dcdt_pkg::ADDR_DATA0 || paddr_i == dcdt_pkg::ADDR_DATA1
                     || paddr_i == dcdt_pkg::ADDR_DATA2)) begin
        send_pend <= 1'b1;
      end else if (start) begin
        send_pend <= 1'b0;
      end
    end
  end

  // rate accumulator, increment is 2^15 times sum of 2^-prescaler
  always_comb begin
    per_inc = (dcdt_pkg::PER_UNIT >> ramp_div[0]) + (dcdt_pkg::PER_UNIT >> ramp_div[1])
            + (dcdt_pkg::PER_UNIT >> ramp_div[2]);
    per_sum = {1'b0, per_acc} + (PER_ACC_W_L + 1)'(per_inc);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      per_acc  <= '0;
      per_tick <= 1'b0;
      per_pend <= 1'b0;
    end else if (!periodic) begin
      // on-demand is the reset mode, no schedule runs
      per_acc  <= '0;
      per_tick <= 1'b0;
      per_pend <= 1'b0;
    end else begin
      per_acc  <= per_sum[PER_ACC_W_L-1:0];
      per_tick <= per_sum[PER_ACC_W_L];
      // ticks keep coming while motors rest
      if (per_tick) begin
        per_pend <= 1'b1;
      end else if (start) begin
        per_pend <= 1'b0;
      end
    end
  end

  // nothing starts at rest unless software wrote or the schedule ticked
  // a tick still pending when periodic mode is switched off is dropped
  assign start     = (state == dcdt_pkg::ST_IDLE)
                     && (send_pend || (periodic && per_pend) || (|motor_active_i));
  assign frame_end = (state == dcdt_pkg::ST_TRAIL) && div_if.half_tick
                     && (half_cnt == dcdt_pkg::TRAIL_LAST);
  // gap is two halves at the minimum divider, three above it
  assign nxm_last  = (chain_clock_divider > dcdt_pkg::DIV_MIN) ? dcdt_pkg::NXM_SLOW_LAST
                                                               : dcdt_pkg::NXM_FAST_LAST;

  // frame sequencer, one step per half clock
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state         <= dcdt_pkg::ST_IDLE;
      half_cnt      <= 2'h0;
      bit_idx       <= dcdt_pkg::BIT_TOP;
      drv_idx       <= 2'h0;
      chain_sck_o   <= 1'b0;
      chain_sdo_o   <= 1'b0;
      chain_sel_n_o <= 1'b1;
    end else if (start) begin
      state         <= dcdt_pkg::ST_LEAD;
      half_cnt      <= 2'h0;
      bit_idx       <= dcdt_pkg::BIT_TOP;
      drv_idx       <= chain_driver_count;
      chain_sel_n_o <= 1'b0;
    end else if (div_if.half_tick) begin
      case (state)
        dcdt_pkg::ST_LEAD: begin
          if (half_cnt == dcdt_pkg::LEAD_LAST) begin
            state       <= dcdt_pkg::ST_BITS;
            half_cnt    <= 2'h0;
            chain_sdo_o <= dgram[drv_idx][bit_idx];
          end else begin
            half_cnt <= half_cnt + 2'h1;
          end
        end
        dcdt_pkg::ST_BITS: begin
          if (half_cnt == 2'h0) begin
            half_cnt    <= 2'h1;
            chain_sck_o <= 1'b1;
          end else begin
            half_cnt    <= 2'h0;
            chain_sck_o <= 1'b0;
            if (bit_idx == 4'h0) begin
              state       <= dcdt_pkg::ST_NXM;
              chain_sdo_o <= 1'b0;
            end else begin
              bit_idx     <= bit_idx - 4'h1;
              chain_sdo_o <= dgram[drv_idx][bit_idx - 4'h1];
            end
          end
        end
        dcdt_pkg::ST_NXM: begin
          if (half_cnt != nxm_last) begin
            half_cnt <= half_cnt + 2'h1;
          end else if (drv_idx == 2'h0) begin
            state    <= dcdt_pkg::ST_TRAIL;
            half_cnt <= 2'h0;
          end else begin
            state       <= dcdt_pkg::ST_BITS;
            half_cnt    <= 2'h0;
            drv_idx     <= drv_idx - 2'h1;
            bit_idx     <= dcdt_pkg::BIT_TOP;
            chain_sdo_o <= dgram[drv_idx - 2'h1][dcdt_pkg::BIT_TOP];
          end
        end
        dcdt_pkg::ST_TRAIL: begin
          if (half_cnt == dcdt_pkg::TRAIL_LAST) begin
            state         <= dcdt_pkg::ST_IDLE;
            chain_sel_n_o <= 1'b1;
          end else begin
            half_cnt <= half_cnt + 2'h1;
          end
        end
        default: begin
          state <= dcdt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // switch pins are asynchronous: two flops before use
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_meta <= 3'h0;
      ref_sync <= 3'h0;
    end else begin
      ref_meta <= ref_i;
      ref_sync <= ref_meta;
    end
  end

  // select idle steers mux to left switches, select active to right
  // switches are caught only at frame start and frame end
  // halt only moves at frame end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      left_sw      <= 3'h0;
      right_sw     <= 3'h0;
      motor_halt_o <= 3'h0;
    end else if (start) begin
      left_sw <= ref_sync;
    end else if (frame_end) begin
      if (refmux) begin
        right_sw     <= ref_sync;
        // the halt releases at this frame only when both left and right switches are clear
        motor_halt_o <= left_sw | ref_sync;
      end else begin
        left_sw      <= ref_sync;
        motor_halt_o <= ref_sync;
      end
    end
  end

  // scaling only while moving unless periodic mode is on
  // periodic mode keeps scaling at zero velocity
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      current_scale_en_o <= 1'b0;
    end else begin
      current_scale_en_o <= periodic || (|motor_active_i);
    end
  end

  // helper: half ticks seen in a frame against the expected length
  always_comb begin
    halves_want = 10'h004 + (10'(chain_driver_count) + 10'h001)
                * (10'h018 + 10'(nxm_last) + 10'h001);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      halves_seen <= 10'h000;
    end else if (start) begin
      halves_seen <= 10'h000;
    end else if (div_if.half_tick) begin
      halves_seen <= halves_seen + 10'h001;
    end
  end

  property p_div_reset;
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(sys_rst_i) |-> (chain_clock_divider == 8'h0f);
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not 15 after reset");

  property p_forbidden_count;
    @(posedge clk_i) disable iff (sys_rst_i)
    (wr_acc && paddr_i == dcdt_pkg::ADDR_CFG && pwdata_i[9:8] == 2'h3)
      |=> (chain_driver_count == $past(chain_driver_count));
  endproperty
  a_forbidden_count: assert property (p_forbidden_count) else $error("count 3 was stored");

  property p_rest_silent;
    @(posedge clk_i) disable iff (sys_rst_i)
    (state == dcdt_pkg::ST_IDLE && !periodic && !send_pend && motor_active_i == 3'h0)
      |=> chain_sel_n_o;
  endproperty
  a_rest_silent: assert property (p_rest_silent) else $error("frame sent at rest");

  property p_periodic_send;
    @(posedge clk_i) disable iff (sys_rst_i)
    (periodic && per_tick && state == dcdt_pkg::ST_IDLE) |-> ##[1:2] !chain_sel_n_o;
  endproperty
  a_periodic_send: assert property (p_periodic_send) else $error("periodic tick not sent");

  property p_frame_len;
    @(posedge clk_i) disable iff (sys_rst_i)
    frame_end && $stable(chain_clock_divider) |-> (halves_seen + 10'h001 == halves_want);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  property p_halt_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!frame_end && !periodic) |=> $stable(motor_halt_o);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt changed outside frame");

  property p_no_scale;
    @(posedge clk_i) disable iff (sys_rst_i)
    (!periodic && motor_active_i == 3'h0) ##1 (!periodic && motor_active_i == 3'h0)
      |-> !current_scale_en_o;
  endproperty
  a_no_scale: assert property (p_no_scale) else $error("scaling at rest");
endmodule
`default_nettype wire

// ===== tb/dcdt_chain_model.sv
`default_nettype none
module dcdt_chain_model (
  // chain pins
  input  wire logic        sck_i,
  input  wire logic        sel_n_i,
  input  wire logic        sdo_i,
  // captured frame
  output logic      [35:0] bits_o,
  output logic      [7:0]  nbits_o,
  output logic      [15:0] frames_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] shift = 36'h0;
  logic [7:0]  cnt   = 8'h00;
  logic [7:0]  base  = 8'h00;
  initial frames_o = 16'h0000;
  // drivers take data on the rising chain clock, only while selected
  always @(posedge sck_i) if (sel_n_i === 1'b0) begin
    shift <= {shift[34:0], sdo_i};
    cnt   <= cnt + 8'h01;
  end
  // bit count is relative to the frame start, so no clear is needed
  always @(negedge sel_n_i) base <= cnt;
  always @(posedge sel_n_i) begin
    bits_o   <= shift;
    nbits_o  <= cnt - base;
    frames_o <= frames_o + 16'h0001;
  end
endmodule
`default_nettype wire

// ===== tb/driver_chain_datagram_timing_test.sv
`default_nettype none
module driver_chain_datagram_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, sys_rst_i, psel_i, penable_i, pwrite_i;
  logic        pready_o, pslverr_o, scale_o, sck_o, sel_n_o, sdo_o, er, ps;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [2:0]  act_i, halt_o, ref_i;
  logic [35:0] bits;
  logic [7:0]  nbits;
  logic [15:0] frames, f0;
  int          bad_count, check_count, len, hi, per, n;

  always #10 clk_i = ~clk_i;

  dcdt_top dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .motor_active_i(act_i), .motor_halt_o(halt_o),
    .current_scale_en_o(scale_o), .ref_i(ref_i), .chain_sck_o(sck_o),
    .chain_sel_n_o(sel_n_o), .chain_sdo_o(sdo_o));
  dcdt_chain_model mdl_u (.sck_i(sck_o), .sel_n_i(sel_n_o), .sdo_i(sdo_o), .bits_o(bits),
    .nbits_o(nbits), .frames_o(frames));

  task chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // apb master: waits for pready, no fixed latency assumed
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    psel_i <= 1'b1;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) bad_count++;
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // wait for 50 cycles of deselected chain
  task quiet;
    int q, k;
    q = 0;
    k = 0;
    while (q < 50 && k < 20000) begin
      @(posedge clk_i);
      q = (sel_n_o === 1'b1) ? q + 1 : 0;
      k++;
    end
    if (k >= 20000) bad_count++;
  endtask

  // frame length, first clock high time and period, in system cycles
  task frame;
    int k, r1, r2;
    k = 0;
    while (sel_n_o !== 1'b0 && k < 40000) begin
      @(posedge clk_i);
      k++;
    end
    len = 0;
    hi = 0;
    r1 = -1;
    r2 = -1;
    ps = 1'b0;
    while (sel_n_o === 1'b0 && len < 20000) begin
      if (sck_o === 1'b1 && ps === 1'b0) begin
        if (r1 < 0) r1 = len;
        else if (r2 < 0) r2 = len;
      end
      if (r1 >= 0 && r2 < 0 && sck_o === 1'b1) hi++;
      ps = sck_o;
      @(posedge clk_i);
      len++;
    end
    per = r2 - r1;
  endtask

  task t_reset;
    f0 = frames;
    chk({sck_o, sel_n_o, halt_o, scale_o}, 36'h10);
    apb(dcdt_pkg::ADDR_CFG, 1'b0, 32'h0);
    chk(rd[11:0], 12'h00f);
    apb(12'h0f0, 1'b0, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h0ff);
    apb(dcdt_pkg::ADDR_CFG, 1'b0, 32'h0);
    chk(rd[11:0], 12'h0ff);
    chk(frames, f0);
    $display("done reset");
  endtask

  task t_one;
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h007);
    quiet();
    apb(dcdt_pkg::ADDR_DATA0, 1'b1, 32'habc);
    frame();
    // 30 halves of 8 cycles, plus the cycle select leads the divider
    chk(len, 30 * 8 + 1);
    chk(per, 16);
    chk(hi, 8);
    chk({nbits, bits[11:0]}, {8'd12, 12'habc});
    chk(scale_o, 1'b0);
    $display("done one driver");
  endtask

  task t_three;
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h208);
    apb(dcdt_pkg::ADDR_DATA2, 1'b1, 32'h789);
    apb(dcdt_pkg::ADDR_DATA1, 1'b1, 32'h456);
    apb(dcdt_pkg::ADDR_DATA0, 1'b1, 32'h123);
    quiet();
    apb(dcdt_pkg::ADDR_DATA0, 1'b1, 32'h123);
    frame();
    // 85 halves of 9 cycles, plus the cycle select leads the divider
    chk(len, 85 * 9 + 1);
    chk(per, 18);
    chk(hi, 9);
    chk(nbits, 8'd36);
    chk(bits, 36'h789456123);
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h307);
    apb(dcdt_pkg::ADDR_CFG, 1'b0, 32'h0);
    chk(rd[11:0], 12'h207);
    $display("done three drivers");
  endtask

  task t_slow;
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h003);
    quiet();
    apb(dcdt_pkg::ADDR_DATA0, 1'b1, 32'h5a5);
    frame();
    chk(per, 16);
    chk(hi, 4);
    $display("done short divider");
  endtask

  task t_halt;
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h007);
    quiet();
    act_i <= 3'h1;
    ref_i <= 3'h1;
    n = 0;
    while (halt_o[0] !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk(halt_o[0], 1'b1);
    act_i <= 3'h0;
    quiet();
    ref_i <= 3'h0;
    f0 = frames;
    repeat (1000) @(posedge clk_i);
    chk(frames, f0);
    chk(halt_o[0], 1'b1);
    apb(dcdt_pkg::ADDR_RAMP, 1'b1, 32'h0);
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'h407);
    n = 0;
    while (halt_o[0] !== 1'b0 && n < 15000) begin
      @(posedge clk_i);
      n++;
    end
    chk({halt_o[0], scale_o}, 2'b01);
    quiet();
    while (sel_n_o !== 1'b0 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    ps = 1'b0;
    repeat (32668) begin
      @(posedge clk_i);
      if (ps === 1'b1 && sel_n_o === 1'b0) n++;
      ps = sel_n_o;
    end
    chk(n, 2);
    // multiplexed switches: left caught at start, right at frame end
    ref_i <= 3'h4;
    apb(dcdt_pkg::ADDR_CFG, 1'b1, 32'hc07);
    n = 0;
    while (halt_o !== 3'h4 && n < 15000) begin
      @(posedge clk_i);
      n++;
    end
    apb(dcdt_pkg::ADDR_STAT, 1'b0, 32'h0);
    chk(rd[11:0], 12'h648);
    $display("done periodic");
  endtask

  initial begin
    clk_i = 1'b0;
    sys_rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i} = 3'h0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    act_i = 3'h0;
    ref_i = 3'h0;
    bad_count = 0;
    check_count = 0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_one();
    t_three();
    t_slow();
    t_halt();
    summarize();
  end

  // watchdog well past the roughly 59500 cycles the tests need
  initial begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule
`default_nettype wire
